// file: src/dram_ctl_pkg.sv
// constants and carrier types for the single-bit dynamic ram controller
// assumes one 250 MHz clock; all strobe timing is counted in cycles of it
// Notes on behaviour
// - wait 200 us, then eight row-strobe cycles
// - never place write edge between both windows
// - hold write strobe high after read strobes rise
// - random cycle at least 200/220/260 ns
// - read-modify-write cycle at least 235/265/310 ns
// - rmw row strobe low at least 140/165/200
// - rmw column strobe low at least 85/105/125
// - column strobe 25 to 50 ns after row
// - page cycle no faster than 100/120/145 ns
// - page read-write cycle at least 130/160/190
// - page column precharge at least 40/50/60
// - write low 30/40/45 ns before row rises
// - nine row bits, then nine column bits
// - refresh every row within four milliseconds
// - refresh 256 rows by row strobe only
package dram_ctl_pkg;
  localparam int CLK_MHZ = 250;
  // slowest grade figures in ns, so one controller serves all grades
  localparam int POWERUP_US = 200;
  localparam int INIT_CYCLES = 8;
  localparam int RCD_NS = 30;
  localparam int RAC_NS = 150;
  localparam int RAS_LOW_NS = 150;
  localparam int RRW_NS = 200;
  localparam int CAS_LOW_NS = 75;
  localparam int CRW_NS = 125;
  localparam int RP_NS = 100;
  localparam int RC_NS = 260;
  localparam int RWC_NS = 310;
  localparam int CP_NS = 60;
  localparam int WRL_NS = 45;
  localparam int CAC_NS = 75;
  localparam int REF_MS = 4;
  localparam int REF_ROWS = 256;
  // least times round up
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int RCD_CYC = (RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int RAS_CYC = (RAS_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RRW_CYC = (RRW_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_CYC = (CAS_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int CRW_CYC = (CRW_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC = (RP_NS * CLK_MHZ + 999) / 1000;
  localparam int CP_CYC = (CP_NS * CLK_MHZ + 999) / 1000;
  localparam int WRL_CYC = (WRL_NS * CLK_MHZ + 999) / 1000;
  localparam int CAC_CYC = (CAC_NS * CLK_MHZ + 999) / 1000;
  localparam int RAC_CYC = (RAC_NS * CLK_MHZ + 999) / 1000;
  localparam int RC_CYC = (RC_NS * CLK_MHZ + 999) / 1000;
  localparam int RWC_CYC = (RWC_NS * CLK_MHZ + 999) / 1000;
  // refresh interval: 4 ms spread over 256 rows, rounded down, with margin
  localparam int REF_INT_CYC = (REF_MS * 1000 * CLK_MHZ) / REF_ROWS - 64;
  localparam int CNT_W = 20;

  typedef enum logic [3:0] {
    ST_POWERUP, ST_INIT_RAS, ST_INIT_PRE, ST_IDLE, ST_ROW, ST_RCD,
    ST_COL, ST_RMW_WR, ST_CAS_PRE, ST_RAS_END, ST_PRE, ST_REF
  } state_t;

  typedef struct packed {
    logic [8:0] addr;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic din;
  } pins_t;

  typedef struct packed {
    logic [17:0] addr;
    logic write;
    logic rmw;
    logic wdata;
  } req_t;

  typedef struct packed {
    state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cyc;
    logic [CNT_W-1:0] ref_cnt;
    logic ref_due;
    logic [3:0] init_n;
    logic [7:0] ref_row;
    req_t req;
    pins_t pins;
    logic rdata;
    logic rvalid;
    logic ready;
  } ctl_state_t;
endpackage

// file: src/dram_ctl.sv
// controller driving a 256K x 1 dynamic ram through its strobe pins
// assumes the memory sits directly on these pins and data returns on read_bit
`timescale 1ns/10ps
module dram_ctl #(
  parameter int POWERUP_CYCLES = dram_ctl_pkg::POWERUP_CYC,
  parameter int REFRESH_INTERVAL = dram_ctl_pkg::REF_INT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // user request side
  input wire logic req_valid,
  input wire dram_ctl_pkg::req_t req_in,
  output logic req_ready,
  output logic rd_valid,
  output logic rd_data,
  // memory pins
  output logic [8:0] muxed_address_pins,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic serial_bit_in,
  input wire logic read_bit
);
  dram_ctl_pkg::ctl_state_t s_reg, s_next;

  function automatic logic [dram_ctl_pkg::CNT_W-1:0] cyc(input int n);
    cyc = dram_ctl_pkg::CNT_W'(n);
  endfunction

  // next-state logic for the whole controller
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.ready = 1'b0;
    s_next.cnt = s_reg.cnt + cyc(1);
    s_next.cyc = s_reg.cyc + cyc(1);
    case (s_reg.st)
      dram_ctl_pkg::ST_POWERUP: begin
        if (s_reg.cnt >= cyc(POWERUP_CYCLES)) begin
          s_next.st = dram_ctl_pkg::ST_INIT_RAS;
          s_next.cnt = '0;
          s_next.pins.ras_n = 1'b0;
        end
      end
      dram_ctl_pkg::ST_INIT_RAS: begin
        if (s_reg.cnt >= cyc(dram_ctl_pkg::RAS_CYC - 1)) begin
          s_next.pins.ras_n = 1'b1;
          s_next.st = dram_ctl_pkg::ST_INIT_PRE;
          s_next.cnt = '0;
          s_next.init_n = s_reg.init_n + 4'h1;
        end
      end
      dram_ctl_pkg::ST_INIT_PRE: begin
        // high long enough that each activation also meets the full cycle time
        if (s_reg.cnt >= cyc(dram_ctl_pkg::RC_CYC - dram_ctl_pkg::RAS_CYC - 1)) begin
          s_next.cnt = '0;
          if (s_reg.init_n >= 4'(dram_ctl_pkg::INIT_CYCLES)) begin
            s_next.st = dram_ctl_pkg::ST_IDLE;
          end else begin
            s_next.st = dram_ctl_pkg::ST_INIT_RAS;
            s_next.pins.ras_n = 1'b0;
          end
        end
      end
      dram_ctl_pkg::ST_IDLE: begin
        s_next.cyc = '0;
        s_next.cnt = '0;
        if (s_reg.ref_due) begin
          // row-only refresh, column strobe stays high
          s_next.ref_due = 1'b0;
          s_next.pins.addr = {1'b0, s_reg.ref_row};
          s_next.ref_row = s_reg.ref_row + 8'h01;
          s_next.st = dram_ctl_pkg::ST_REF;
        end else if (req_valid) begin
          s_next.req = req_in;
          s_next.ready = 1'b1;
          s_next.pins.addr = req_in.addr[17:9];
          s_next.st = dram_ctl_pkg::ST_ROW;
        end
      end
      dram_ctl_pkg::ST_ROW: begin
        // row address set up one cycle before the strobe falls
        s_next.pins.ras_n = 1'b0;
        // early write: we low ahead of column strobe keeps output floating
        s_next.pins.we_n = ~(s_reg.req.write & ~s_reg.req.rmw);
        s_next.pins.din = s_reg.req.wdata;
        s_next.cyc = '0;
        s_next.cnt = '0;
        s_next.st = dram_ctl_pkg::ST_RCD;
      end
      dram_ctl_pkg::ST_RCD: begin
        if (s_reg.cnt == '0) begin
          s_next.pins.addr = s_reg.req.addr[8:0];
        end
        // column strobe falls at the minimum row-to-column delay
        if (s_reg.cnt >= cyc(dram_ctl_pkg::RCD_CYC - 1)) begin
          s_next.pins.cas_n = 1'b0;
          s_next.cnt = '0;
          s_next.st = dram_ctl_pkg::ST_COL;
        end
      end
      dram_ctl_pkg::ST_COL: begin
        // sample after column access time; output floats before that
        // the row access time is the later one at minimum row-to-column delay
        if (!s_reg.req.write && s_reg.cyc == cyc(dram_ctl_pkg::RAC_CYC)) begin
          s_next.rdata = read_bit;
          s_next.rvalid = 1'b1;
        end
        if (s_reg.req.rmw && s_reg.cyc == cyc(dram_ctl_pkg::RAC_CYC)) begin
          // write edge well after both strobes: read-write cycle
          s_next.rdata = read_bit;
          s_next.rvalid = 1'b1;
          s_next.pins.we_n = 1'b0;
          s_next.cnt = '0;
          s_next.st = dram_ctl_pkg::ST_RMW_WR;
        end else if (!s_reg.req.rmw && s_reg.cyc >= cyc(dram_ctl_pkg::RAC_CYC)) begin
          s_next.pins.cas_n = 1'b1;
          s_next.cnt = '0;
          s_next.st = dram_ctl_pkg::ST_RAS_END;
        end
      end
      dram_ctl_pkg::ST_RMW_WR: begin
        // write low long enough before strobes rise, cas width for rmw
        if (s_reg.cnt >= cyc(dram_ctl_pkg::CRW_CYC)) begin
          s_next.pins.cas_n = 1'b1;
          s_next.cnt = '0;
          s_next.st = dram_ctl_pkg::ST_RAS_END;
        end
      end
      dram_ctl_pkg::ST_RAS_END: begin
        // row strobe held for its longer rmw width and write lead
        if (s_reg.cyc >= cyc(s_reg.req.rmw ? dram_ctl_pkg::RRW_CYC : dram_ctl_pkg::RAS_CYC)
            && s_reg.cnt >= cyc(dram_ctl_pkg::WRL_CYC)) begin
          s_next.pins.ras_n = 1'b1;
          s_next.cnt = '0;
          s_next.st = dram_ctl_pkg::ST_PRE;
        end
      end
      dram_ctl_pkg::ST_REF: begin
        // strobe falls one cycle after the refresh row is set up
        s_next.pins.ras_n = 1'b0;
        if (s_reg.cyc >= cyc(dram_ctl_pkg::RAS_CYC)) begin
          s_next.pins.ras_n = 1'b1;
          s_next.cnt = '0;
          s_next.st = dram_ctl_pkg::ST_PRE;
        end
      end
      dram_ctl_pkg::ST_PRE: begin
        // write strobe raised only after row strobe is back high
        s_next.pins.we_n = 1'b1;
        // precharge then full cycle time, rmw uses the longer one
        if (s_reg.cnt >= cyc(dram_ctl_pkg::RP_CYC)
            && s_reg.cyc >= cyc(s_reg.req.rmw ? dram_ctl_pkg::RWC_CYC : dram_ctl_pkg::RC_CYC))
            begin
          s_next.req.rmw = 1'b0;
          s_next.st = dram_ctl_pkg::ST_IDLE;
        end
      end
      default: s_next.st = dram_ctl_pkg::ST_IDLE;
    endcase
    // refresh timer runs always; placed last so a new due flag beats the clear
    if (s_reg.ref_cnt >= cyc(REFRESH_INTERVAL)) begin
      s_next.ref_cnt = '0;
      s_next.ref_due = 1'b1;
    end else begin
      s_next.ref_cnt = s_reg.ref_cnt + cyc(1);
    end
  end

  // state register; page mode is not issued, so page limits are never approached
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '{st: dram_ctl_pkg::ST_POWERUP, cnt: '0, cyc: '0, ref_cnt: '0,
                 ref_due: 1'b0, init_n: 4'h0, ref_row: 8'h00, req: '0,
                 pins: '{addr: 9'h000, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, din: 1'b0},
                 rdata: 1'b0, rvalid: 1'b0, ready: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops, except req_ready, decoded from the state and ref_due flops
  assign req_ready = s_reg.st == dram_ctl_pkg::ST_IDLE && !s_reg.ref_due;
  assign rd_valid = s_reg.rvalid;
  assign rd_data = s_reg.rdata;
  assign muxed_address_pins = s_reg.pins.addr;
  assign ras_n = s_reg.pins.ras_n;
  assign cas_n = s_reg.pins.cas_n;
  assign we_n = s_reg.pins.we_n;
  assign serial_bit_in = s_reg.pins.din;
endmodule

// file: test/dram_ctl_props.sv
// pin timing checker bound into dram_ctl
// assumes ref_clk at 250 MHz; limits are slow-grade cycle counts
`timescale 1ns/10ps
module dram_ctl_props #(
  parameter int POWERUP_CYCLES = 20,
  parameter int REFRESH_INTERVAL = 200
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // memory pins
  input wire logic [8:0] muxed_address_pins,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [19:0] up_reg;
  logic [7:0] rlo_reg, clo_reg, wlo_reg, gap_reg;
  logic rmw_reg;
  // strobe low times; gap saturates so idle spells never wrap
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {up_reg, rlo_reg, clo_reg, wlo_reg, rmw_reg} <= '0;
      gap_reg <= 8'hFF;
    end else begin
      up_reg <= up_reg + 20'h00001;
      rlo_reg <= ras_n ? 8'h00 : rlo_reg + 8'h01;
      clo_reg <= cas_n ? 8'h00 : clo_reg + 8'h01;
      wlo_reg <= we_n ? 8'h00 : wlo_reg + 8'h01;
      gap_reg <= $fell(ras_n) ? 8'h01 : gap_reg + {7'h00, gap_reg != 8'hFF};
      if ($fell(we_n) && !cas_n) rmw_reg <= 1'b1;
      else if ($fell(ras_n)) rmw_reg <= 1'b0;
    end
  end
  powerup_wait_a: assert property ($fell(ras_n) |->
    up_reg >= POWERUP_CYCLES) else $error("early row strobe");
  col_delay_a: assert property ($fell(cas_n) |->
    !$past(ras_n, 8) && $past(ras_n, 18)) else $error("bad row-to-column delay");
  row_cycle_a: assert property ($fell(ras_n) |->
    gap_reg >= (rmw_reg ? 8'h4E : 8'h41)) else $error("row cycle too short");
  rmw_row_a: assert property ($rose(ras_n) && rmw_reg |->
    rlo_reg >= 8'h32) else $error("rmw row strobe short");
  rmw_col_a: assert property ($rose(cas_n) && rmw_reg |->
    clo_reg >= 8'h20) else $error("rmw column strobe short");
  write_lead_a: assert property ($rose(ras_n) && !$past(we_n) |->
    wlo_reg >= 8'h0C) else $error("write lead short");
  late_write_a: assert property ($fell(we_n) && !cas_n |->
    clo_reg >= 8'h13 && rlo_reg >= 8'h26) else $error("write in undefined window");
  addr_stable_a: assert property ($fell(ras_n) || $fell(cas_n) |->
    $stable(muxed_address_pins)) else $error("address moved at strobe");
endmodule
bind dram_ctl dram_ctl_props #(
  .POWERUP_CYCLES(POWERUP_CYCLES), .REFRESH_INTERVAL(REFRESH_INTERVAL)
) dram_ctl_props_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .muxed_address_pins(muxed_address_pins),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));

// file: test/dram_model.sv
// behavioural 256K x 1 dynamic ram answering on read_bit
// assumes slow-grade access times; output toggles when not driven
`timescale 1ns/10ps
module dram_model (
  // strobes and address
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [8:0] muxed_address_pins,
  // data
  input wire logic serial_bit_in,
  output logic read_bit
);
  logic mem [0:262143];
  logic [8:0] row;
  logic [17:0] a;
  logic rd = 1'b0;
  realtime t_r = 0;
  realtime t_c = 0;
  initial read_bit = 1'b0;
  // row latch
  always @(negedge ras_n) begin
    row = muxed_address_pins;
    t_r = $realtime;
  end
  // column latch; low write strobe here is an early write
  always @(negedge cas_n) begin
    a = {row, muxed_address_pins};
    t_c = $realtime;
    rd = we_n;
    if (!we_n) mem[a] = serial_bit_in;
  end
  // late write stores the bit, read data stays out
  always @(negedge we_n) if (!cas_n) mem[a] = serial_bit_in;
  // valid after both access times, so a late column strobe delays it
  // outside that only junk
  always #1 read_bit = (!cas_n && rd && $realtime >= t_r + 150 && $realtime >= t_c + 75)
    ? mem[a] : ~read_bit;
endmodule

// file: test/tb_top.sv
// bench for dram_ctl with a behavioural memory on its pins
// assumes short power-up and refresh counts to keep the run brief
`timescale 1ns/10ps
module tb_top;
  localparam int PWR = 20;
  localparam int REF = 200;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  dram_ctl_pkg::req_t req_in = '0;
  logic req_ready, rd_valid, rd_data, ras_n, cas_n, we_n, serial_bit_in, read_bit;
  logic [8:0] muxed_address_pins;
  int failures = 0;
  int n_checks = 0;
  int n_ras = 0;
  int n_cas = 0;
  // clock and strobe counts
  initial forever #2 ref_clk = ~ref_clk;
  always @(negedge ras_n) n_ras++;
  always @(negedge cas_n) n_cas++;
  dram_ctl #(.POWERUP_CYCLES(PWR), .REFRESH_INTERVAL(REF)) dram_ctl_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_in(req_in),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .ras_n(ras_n),
    .muxed_address_pins(muxed_address_pins), .cas_n(cas_n), .we_n(we_n),
    .serial_bit_in(serial_bit_in), .read_bit(read_bit));
  dram_model dram_model_i (
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .muxed_address_pins(muxed_address_pins),
    .serial_bit_in(serial_bit_in), .read_bit(read_bit));
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %b expected %b", $time, g, e);
    end
  endtask
  task automatic hang();
    failures++;
    $display("ERROR %0t wait ran out", $time);
    end_sim();
  endtask
  // one request, valid held until taken; reads wait for the data pulse
  task automatic access(input logic [17:0] a, input logic w, r, d, output logic q);
    int i;
    logic rdy;
    i = 0;
    req_valid <= 1'b1;
    req_in <= {a, w, r, d};
    // ready looked at mid-cycle, so the taking edge is known without a race
    do begin
      @(negedge ref_clk);
      rdy = req_ready;
      @(posedge ref_clk);
    end while (rdy !== 1'b1 && ++i < 3000);
    if (i >= 3000) hang();
    req_valid <= 1'b0;
    i = 0;
    if (!w) do @(negedge ref_clk); while (rd_valid !== 1'b1 && ++i < 200);
    if (i >= 200) hang();
    q = rd_data;
    @(posedge ref_clk);
  endtask
  // strobes idle in reset, then pause and activation burst before ready
  task automatic t_power();
    int c;
    chk(ras_n & cas_n & ~req_ready, 1'b1);
    sys_rst <= 1'b0;
    for (c = 0; c < 3000 && req_ready !== 1'b1; c++) @(posedge ref_clk);
    if (c >= 3000) hang();
    chk(c >= PWR && n_ras >= 8, 1'b1);
  endtask
  // corners where swapped row and column halves would alias
  task automatic t_rw();
    logic [17:0] ad [4] = '{18'h00001, 18'h00200, 18'h3FFFF, 18'h00000};
    logic q;
    for (int k = 0; k < 4; k++) access(ad[k], 1'b1, 1'b0, ~k[0], q);
    for (int k = 0; k < 4; k++) begin
      access(ad[k], 1'b0, 1'b0, k[0], q);
      chk(q, ~k[0]);
    end
  endtask
  // rmw returns the old bit and leaves the new one
  task automatic t_rmw();
    logic q;
    access(18'h00001, 1'b0, 1'b1, 1'b0, q);
    chk(q, 1'b1);
    access(18'h00001, 1'b0, 1'b0, 1'b1, q);
    chk(q, 1'b0);
  endtask
  // idle rows still refreshed, column strobe left high
  task automatic t_ref();
    int r0, c0;
    r0 = n_ras;
    c0 = n_cas;
    repeat (3 * REF) @(posedge ref_clk);
    chk(n_ras - r0 >= 2 && n_cas == c0, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    t_power();
    t_rw();
    t_rmw();
    t_ref();
    end_sim();
  end
endmodule
